// file: rtl/sbm_consts.vh
// Constants for the serial bank mapper: register offsets, field positions,
// reset values and sequence counts.
// Assumes inclusion by bare name from the mapper module only.
`ifndef SBM_CONSTS_VH
`define SBM_CONSTS_VH

// =====================================================================
// Register offsets in the CPU program window
`define SBM_OFS_CFG 16'h8000
`define SBM_OFS_PAT_LO 16'ha000
`define SBM_OFS_PAT_HI 16'hc000
`define SBM_OFS_PRG 16'he000

// =====================================================================
// Register select from CPU address bits 14:13
`define SBM_SEL_CFG 2'h0
`define SBM_SEL_PAT_LO 2'h1
`define SBM_SEL_PAT_HI 2'h2
`define SBM_SEL_PRG 2'h3

// =====================================================================
// Serial write data bits
`define SBM_DATA_SERIAL_BIT 0
`define SBM_DATA_CLEAR_BIT 7
`define SBM_SHIFT_WRITES 3'h5
`define SBM_LAST_WRITE 3'h4

// =====================================================================
// Configuration fields
`define SBM_CFG_MIRROR_LSB 0
`define SBM_CFG_PRGMODE_LSB 2
`define SBM_CFG_PATSIZE_BIT 4
`define SBM_MIRROR_VERT 2'h2
`define SBM_MIRROR_HORZ 2'h3
`define SBM_PRGMODE_FIX_LOW 2'h2
`define SBM_PRGMODE_FIX_HIGH 2'h3
`define SBM_SEGMENT_BIT 4

// =====================================================================
// Reset values
`define SBM_RST_CFG 5'h0c
`define SBM_RST_PAT_LO 5'h00
`define SBM_RST_PAT_HI 5'h00
`define SBM_RST_PRG 5'h00
`define SBM_RST_SHIFT 5'h00
`define SBM_RST_COUNT 3'h0

// =====================================================================
// Program ROM sizes in kilobytes
`define SBM_PRG_KB_512 512
`define SBM_PRG_KB_1024 1024

`endif

// file: rtl/sbm_mapper.v
// Serial bank mapper: CPU writes load four 5-bit registers serially;
// outputs program ROM, pattern memory and name table address mapping.
// Assumes CPU address and data stay stable while the program strobe is low.
// Assumes every CPU pin holds each level for at least two clocks.
`timescale 1ns/10ps
`default_nettype none
`include "sbm_consts.vh"

module sbm_mapper #(
    parameter PRG_KB = 1024,
    parameter SYNC_W = 2
) (
    // Clock, reset, enable
    input wire clock_i,
    input wire reset_i,
    input wire clk_en_i,
    // CPU cartridge bus
    input wire cpu_prg_n_i,
    input wire cpu_rw_i,
    input wire [14:0] cpu_addr_i,
    input wire [7:0] cpu_data_i,
    // Pattern memory bus
    input wire [12:0] ppu_addr_i,
    input wire ppu_a10_i,
    input wire ppu_a11_i,
    // Mapped addresses
    output reg [19:0] program_rom_addr_o,
    output reg [16:0] pattern_memory_addr_o,
    output reg nametable_a10_o,
    // State view
    output reg [2:0] write_count_o,
    output reg [4:0] mapper_configuration_o
);

    // =================================================================
    // Pin synchronisers
    localparam PIN_W = SYNC_W + 10;

    wire [PIN_W-1:0] pin_raw;
    wire [PIN_W-1:0] pin_filt;

    assign pin_raw = {cpu_addr_i[14:13], cpu_data_i, cpu_rw_i, cpu_prg_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
            reg s1_reg;
            reg s2_reg;
            reg s3_reg;
            reg filt_reg;
            always @(posedge clock_i) begin
                if (reset_i) begin
                    s1_reg <= 1'b1;
                    s2_reg <= 1'b1;
                    s3_reg <= 1'b1;
                    filt_reg <= 1'b1;
                end else if (clk_en_i) begin
                    s1_reg <= pin_raw[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        filt_reg <= s3_reg;
                    end
                end
            end
            assign pin_filt[gi] = filt_reg;
        end
    endgenerate

    // =================================================================
    // Filtered write fields
    wire [7:0] sync_data;
    wire [1:0] sync_sel;

    assign sync_data = pin_filt[SYNC_W+7:SYNC_W];
    assign sync_sel = pin_filt[SYNC_W+9:SYNC_W+8];

    // =================================================================
    // Write strobe detection
    wire prg_n_filt;
    wire rw_filt;
    reg prg_n_last_reg;
    wire write_evt;

    assign prg_n_filt = pin_filt[0];
    assign rw_filt = pin_filt[1];
    assign write_evt = prg_n_last_reg & ~prg_n_filt & ~rw_filt;

    always @(posedge clock_i) begin
        if (reset_i) begin
            prg_n_last_reg <= 1'b1;
        end else if (clk_en_i) begin
            prg_n_last_reg <= prg_n_filt;
        end
    end

    // =================================================================
    // Serial loader
    reg [4:0] shift_reg;
    reg [4:0] shift_next;
    reg [2:0] count_reg;
    reg [2:0] count_next;
    reg [4:0] cfg_reg;
    reg [4:0] cfg_next;
    reg [4:0] pat_lo_reg;
    reg [4:0] pat_lo_next;
    reg [4:0] pat_hi_reg;
    reg [4:0] pat_hi_next;
    reg [4:0] prg_reg;
    reg [4:0] prg_next;
    wire serial_bit;
    wire clear_bit;
    wire [1:0] reg_sel;
    wire [4:0] load_value;

    assign serial_bit = sync_data[`SBM_DATA_SERIAL_BIT];
    assign clear_bit = sync_data[`SBM_DATA_CLEAR_BIT];
    assign reg_sel = sync_sel;
    assign load_value = {serial_bit, shift_reg[4:1]};

    always @* begin
        shift_next = shift_reg;
        count_next = count_reg;
        cfg_next = cfg_reg;
        pat_lo_next = pat_lo_reg;
        pat_hi_next = pat_hi_reg;
        prg_next = prg_reg;
        if (write_evt) begin
            if (clear_bit) begin
                shift_next = `SBM_RST_SHIFT;
                count_next = `SBM_RST_COUNT;
            end else if (count_reg == `SBM_LAST_WRITE) begin
                shift_next = `SBM_RST_SHIFT;
                count_next = `SBM_RST_COUNT;
                case (reg_sel)
                    `SBM_SEL_CFG: begin
                        cfg_next = load_value;
                    end
                    `SBM_SEL_PAT_LO: begin
                        pat_lo_next = load_value;
                    end
                    `SBM_SEL_PAT_HI: begin
                        pat_hi_next = load_value;
                    end
                    `SBM_SEL_PRG: begin
                        prg_next = load_value;
                    end
                    default: begin
                        cfg_next = cfg_reg;
                    end
                endcase
            end else begin
                shift_next = load_value;
                count_next = count_reg + 3'h1;
            end
        end
    end

    always @(posedge clock_i) begin
        if (reset_i) begin
            shift_reg <= `SBM_RST_SHIFT;
            count_reg <= `SBM_RST_COUNT;
        end else if (clk_en_i) begin
            shift_reg <= shift_next;
            count_reg <= count_next;
        end
    end

    always @(posedge clock_i) begin
        if (reset_i) begin
            cfg_reg <= `SBM_RST_CFG;
            pat_lo_reg <= `SBM_RST_PAT_LO;
            pat_hi_reg <= `SBM_RST_PAT_HI;
            prg_reg <= `SBM_RST_PRG;
        end else if (clk_en_i) begin
            cfg_reg <= cfg_next;
            pat_lo_reg <= pat_lo_next;
            pat_hi_reg <= pat_hi_next;
            prg_reg <= prg_next;
        end
    end

    // =================================================================
    // Configuration fields
    wire [1:0] mirror_mode;
    wire [1:0] prg_mode;
    wire pat_4k;

    assign mirror_mode = cfg_reg[`SBM_CFG_MIRROR_LSB+1:`SBM_CFG_MIRROR_LSB];
    assign prg_mode = cfg_reg[`SBM_CFG_PRGMODE_LSB+1:`SBM_CFG_PRGMODE_LSB];
    assign pat_4k = cfg_reg[`SBM_CFG_PATSIZE_BIT];

    // =================================================================
    // 256K segment selection
    reg [1:0] segment;

    always @* begin
        segment = 2'h0;
        if (PRG_KB == `SBM_PRG_KB_512) begin
            segment = {1'b0, pat_lo_reg[`SBM_SEGMENT_BIT]};
        end else if (PRG_KB == `SBM_PRG_KB_1024) begin
            if (pat_4k) begin
                segment = {pat_hi_reg[`SBM_SEGMENT_BIT], pat_lo_reg[`SBM_SEGMENT_BIT]};
            end else begin
                segment = {pat_lo_reg[`SBM_SEGMENT_BIT], 1'b0};
            end
        end
    end

    // =================================================================
    // Program bank selection
    reg [3:0] prg_bank;
    wire cpu_a14;

    assign cpu_a14 = cpu_addr_i[14];

    always @* begin
        prg_bank = prg_reg[3:0];
        case (prg_mode)
            `SBM_PRGMODE_FIX_LOW: begin
                if (cpu_a14) begin
                    prg_bank = prg_reg[3:0];
                end else begin
                    prg_bank = 4'h0;
                end
            end
            `SBM_PRGMODE_FIX_HIGH: begin
                if (cpu_a14) begin
                    prg_bank = 4'hf;
                end else begin
                    prg_bank = prg_reg[3:0];
                end
            end
            default: begin
                prg_bank = {prg_reg[3:1], cpu_a14};
            end
        endcase
    end

    // =================================================================
    // Pattern bank selection
    reg [4:0] pat_bank;
    wire ppu_a12;

    assign ppu_a12 = ppu_addr_i[12];

    always @* begin
        pat_bank = pat_lo_reg;
        if (pat_4k) begin
            if (ppu_a12) begin
                pat_bank = pat_hi_reg;
            end else begin
                pat_bank = pat_lo_reg;
            end
        end else begin
            pat_bank = {pat_lo_reg[4:1], ppu_a12};
        end
    end

    // =================================================================
    // Name table mirroring
    reg nt_a10;

    always @* begin
        nt_a10 = 1'b0;
        case (mirror_mode)
            `SBM_MIRROR_VERT: begin
                nt_a10 = ppu_a10_i;
            end
            `SBM_MIRROR_HORZ: begin
                nt_a10 = ppu_a11_i;
            end
            default: begin
                nt_a10 = 1'b0;
            end
        endcase
    end

    // =================================================================
    // Registered outputs
    always @(posedge clock_i) begin
        if (reset_i) begin
            program_rom_addr_o <= 20'h00000;
        end else if (clk_en_i) begin
            program_rom_addr_o <= {segment, prg_bank, cpu_addr_i[13:0]};
        end
    end

    always @(posedge clock_i) begin
        if (reset_i) begin
            pattern_memory_addr_o <= 17'h00000;
        end else if (clk_en_i) begin
            pattern_memory_addr_o <= {pat_bank, ppu_addr_i[11:0]};
        end
    end

    always @(posedge clock_i) begin
        if (reset_i) begin
            nametable_a10_o <= 1'b0;
        end else if (clk_en_i) begin
            nametable_a10_o <= nt_a10;
        end
    end

    // =================================================================
    // State view outputs
    always @(posedge clock_i) begin
        if (reset_i) begin
            write_count_o <= 3'h0;
        end else if (clk_en_i) begin
            write_count_o <= count_reg;
        end
    end

    always @(posedge clock_i) begin
        if (reset_i) begin
            mapper_configuration_o <= `SBM_RST_CFG;
        end else if (clk_en_i) begin
            mapper_configuration_o <= cfg_reg;
        end
    end

endmodule // sbm_mapper

`default_nettype wire

// file: dv/sbm_mapper_checker.sv
// Concurrent checks on the serial bank mapper ports.
// Assumes one clock domain with the mapper outputs one cycle behind.
`timescale 1ns/10ps
`default_nettype none
module sbm_mapper_checker #(
    parameter PRG_KB = 1024
) (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // CPU and pattern buses
    input wire logic cpu_prg_n_i,
    input wire logic cpu_rw_i,
    input wire logic [14:0] cpu_addr_i,
    input wire logic [7:0] cpu_data_i,
    input wire logic [12:0] ppu_addr_i,
    input wire logic ppu_a10_i,
    input wire logic ppu_a11_i,
    // Mapper outputs
    input wire logic [19:0] program_rom_addr_o,
    input wire logic [16:0] pattern_memory_addr_o,
    input wire logic nametable_a10_o,
    input wire logic [2:0] write_count_o,
    input wire logic [4:0] mapper_configuration_o
);
    // =====================================================================
    // Assertions
    logic run_q;
    always @(posedge clock_i) begin
        run_q <= clk_en_i && !reset_i;
    end
    logic rst_q;
    always @(posedge clock_i) begin
        rst_q <= reset_i;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    a_prg_offset: assert property (run_q |-> program_rom_addr_o[13:0] == $past(cpu_addr_i[13:0]))
        else $error("program offset wrong");
    a_pat_offset: assert property (run_q |-> pattern_memory_addr_o[11:0] == $past(ppu_addr_i[11:0]))
        else $error("pattern offset wrong");
    a_mirror_single: assert property (run_q && !mapper_configuration_o[1] |-> !nametable_a10_o)
        else $error("single screen wrong");
    a_mirror_two: assert property (run_q && mapper_configuration_o[1] |-> nametable_a10_o ==
        (mapper_configuration_o[0] ? $past(ppu_a11_i) : $past(ppu_a10_i))) else $error("mirroring wrong");
    a_prg_fix_high: assert property (run_q && mapper_configuration_o[3:2] == 2'h3
        && $past(cpu_addr_i[14]) |-> program_rom_addr_o[17:14] == 4'hf) else $error("fixed high bank wrong");
    a_prg_fix_low: assert property (run_q && mapper_configuration_o[3:2] == 2'h2
        && !$past(cpu_addr_i[14]) |-> program_rom_addr_o[17:14] == 4'h0) else $error("fixed low bank wrong");
    a_prg_pair: assert property (run_q && !mapper_configuration_o[3]
        |-> program_rom_addr_o[14] == $past(cpu_addr_i[14])) else $error("32K bank step wrong");
    a_count_step: assert property ($changed(write_count_o)
        |-> write_count_o == $past(write_count_o) + 3'h1 || write_count_o == 3'h0) else $error("count step wrong");
    a_reset_clear: assert property (disable iff (1'b0) rst_q
        |-> write_count_o == 3'h0 && mapper_configuration_o == 5'h0c) else $error("reset state wrong");
    c_vert: cover property (run_q && mapper_configuration_o[1:0] == 2'h2);
    c_fifth: cover property (write_count_o == 3'h4);
    c_split: cover property (mapper_configuration_o[4] && mapper_configuration_o[3:2] == 2'h2);
endmodule // sbm_mapper_checker
bind sbm_mapper sbm_mapper_checker #(.PRG_KB(PRG_KB)) u_chk (.clock_i(clock_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .cpu_prg_n_i(cpu_prg_n_i), .cpu_rw_i(cpu_rw_i), .cpu_addr_i(cpu_addr_i),
    .cpu_data_i(cpu_data_i), .ppu_addr_i(ppu_addr_i), .ppu_a10_i(ppu_a10_i), .ppu_a11_i(ppu_a11_i),
    .program_rom_addr_o(program_rom_addr_o), .pattern_memory_addr_o(pattern_memory_addr_o),
    .nametable_a10_o(nametable_a10_o), .write_count_o(write_count_o),
    .mapper_configuration_o(mapper_configuration_o));
`default_nettype wire

// file: dv/sbm_cpu_model.sv
// CPU bus model: program-area writes and reads on the cartridge bus.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module sbm_cpu_model (
    // Clock
    input wire logic clock_i,
    // CPU cartridge bus
    output logic prg_n_o,
    output logic rw_o,
    output logic [14:0] addr_o,
    output logic [7:0] data_o
);
    // =====================================================================
    // Bus cycles
    initial begin
        prg_n_o = 1'b1;
        rw_o = 1'b1;
        addr_o = 15'h0;
        data_o = 8'h5a;
    end
    task automatic access(input logic [14:0] a, input logic [7:0] d, input logic w, input int ln);
        addr_o <= a;
        data_o <= d;
        rw_o <= ~w;
        prg_n_o <= 1'b0;
        repeat (ln) @(posedge clock_i);
        prg_n_o <= 1'b1;
        rw_o <= 1'b1;
        data_o <= ~d;
        repeat (ln) @(posedge clock_i);
    endtask
    task automatic load(input logic [14:0] a, input logic [4:0] v, input int ln);
        for (int i = 0; i < 5; i++) begin
            access(a, {1'b0, 6'h15 ^ 6'(i), v[i]}, 1'b1, ln);
        end
    endtask
    task automatic set_addr(input logic [14:0] a);
        addr_o <= a;
    endtask
endmodule // sbm_cpu_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the serial bank mapper.
// Assumes the CPU model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb;
    typedef struct packed {logic [19:0] program_rom; logic [19:0] prg5; logic [16:0] pat;
        logic nt; logic [2:0] cnt; logic [4:0] cfg;} sbm_exp_t;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic [12:0] ppu_addr_i = 13'h0;
    logic ppu_a10_i = 1'b0;
    logic ppu_a11_i = 1'b0;
    logic probe_v = 1'b0;
    wire logic prg_n, rw, nt;
    wire logic [14:0] addr;
    wire logic [7:0] data;
    wire logic [19:0] prg_addr, prg_addr_512;
    wire logic [16:0] pat_addr;
    wire logic [2:0] cnt;
    wire logic [4:0] cfg_o;
    logic [4:0] m_cfg = 5'h0c, m_lo = 5'h0, m_hi = 5'h0, m_prg = 5'h0;
    logic [2:0] m_cnt = 3'h0;
    logic [31:0] rng = 32'h34463be1;
    int error_cnt = 0, checks_done = 0;
    sbm_exp_t expq[$];
    sbm_exp_t w_e, last_e;
    always #25 clock_i = ~clock_i;
    sbm_cpu_model cpu (.clock_i(clock_i), .prg_n_o(prg_n), .rw_o(rw), .addr_o(addr), .data_o(data));
    sbm_mapper #(.PRG_KB(1024)) uut (.clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .cpu_prg_n_i(prg_n), .cpu_rw_i(rw), .cpu_addr_i(addr), .cpu_data_i(data), .ppu_addr_i(ppu_addr_i),
        .ppu_a10_i(ppu_a10_i), .ppu_a11_i(ppu_a11_i), .program_rom_addr_o(prg_addr),
        .pattern_memory_addr_o(pat_addr), .nametable_a10_o(nt), .write_count_o(cnt), .mapper_configuration_o(cfg_o));
    sbm_mapper #(.PRG_KB(512)) uut_512 (.clock_i(clock_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
        .cpu_prg_n_i(prg_n), .cpu_rw_i(rw), .cpu_addr_i(addr), .cpu_data_i(data), .ppu_addr_i(ppu_addr_i),
        .ppu_a10_i(ppu_a10_i), .ppu_a11_i(ppu_a11_i), .program_rom_addr_o(prg_addr_512),
        .pattern_memory_addr_o(), .nametable_a10_o(), .write_count_o(), .mapper_configuration_o());
    // =====================================================================
    // Helpers
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic ld(input logic [1:0] sel, input logic [4:0] v, input int ln);
        void'(xs());
        cpu.load({sel, rng[12:0]}, v, ln);
        case (sel)
            2'h0: m_cfg = v;
            2'h1: m_lo = v;
            2'h2: m_hi = v;
            default: m_prg = v;
        endcase
    endtask
    task automatic probe(input logic [14:0] a, input logic [12:0] p);
        logic [3:0] bank;
        logic [1:0] seg;
        logic [4:0] pb;
        void'(xs());
        case (m_cfg[3:2])
            2'h2: bank = a[14] ? m_prg[3:0] : 4'h0;
            2'h3: bank = a[14] ? 4'hf : m_prg[3:0];
            default: bank = {m_prg[3:1], a[14]};
        endcase
        seg = m_cfg[4] ? {m_hi[4], m_lo[4]} : {m_lo[4], 1'b0};
        pb = m_cfg[4] ? (p[12] ? m_hi : m_lo) : {m_lo[4:1], p[12]};
        cpu.set_addr(a);
        ppu_addr_i <= p;
        ppu_a10_i <= rng[0];
        ppu_a11_i <= rng[1];
        last_e = '{{seg, bank, a[13:0]}, {1'b0, m_lo[4], bank, a[13:0]}, {pb, p[11:0]},
            m_cfg[1] ? rng[m_cfg[0]] : 1'b0, m_cnt, m_cfg};
        expq.push_back(last_e);
        @(posedge clock_i);
        probe_v <= 1'b1;
        @(posedge clock_i);
        probe_v <= 1'b0;
    endtask
    task automatic freeze();
        clk_en_i <= 1'b0;
        void'(xs());
        ppu_addr_i <= rng[12:0];
        ppu_a10_i <= rng[13];
        ppu_a11_i <= rng[14];
        cpu.set_addr(rng[30:16]);
        expq.push_back(last_e);
        @(posedge clock_i);
        probe_v <= 1'b1;
        @(posedge clock_i);
        probe_v <= 1'b0;
        clk_en_i <= 1'b1;
    endtask
    // =====================================================================
    // Scoreboard
    always @(negedge clock_i) begin
        if (probe_v) begin
            w_e = expq.pop_front();
            check(prg_addr, w_e.program_rom);
            check(prg_addr_512, w_e.prg5);
            check(pat_addr, w_e.pat);
            check(nt, w_e.nt);
            check(cnt, w_e.cnt);
            check(cfg_o, w_e.cfg);
        end
    end
    // =====================================================================
    // Sequence
    initial begin
        repeat (6) @(posedge clock_i);
        reset_i <= 1'b0;
        probe(15'h0123, 13'h0000);
        probe(15'h7ffc, 13'h1fff);
        $display("test initial mapping done");
        for (int i = 0; i < 16; i++) begin
            void'(xs());
            ld(2'h1, rng[4:0], 4);
            ld(2'h2, rng[9:5], 9);
            ld(2'h3, rng[14:10], 4);
            ld(2'h0, {rng[15], i[3:0]}, 4);
            for (int j = 0; j < 4; j++) begin
                probe({rng[17 + j], 14'(xs())}, 13'(xs()));
            end
            freeze();
        end
        $display("test mode sweep done");
        cpu.access(15'h4000, 8'h01, 1'b1, 4);
        cpu.access(15'h4000, 8'h00, 1'b0, 4);
        m_cnt = 3'h1;
        probe(15'h0, 13'h0);
        cpu.access(15'h4000, 8'h81, 1'b1, 9);
        m_cnt = 3'h0;
        probe(15'h4000, 13'h0);
        ld(2'h3, 5'h1a, 4);
        probe(15'h0, 13'h1000);
        cpu.access(15'h0, 8'h01, 1'b1, 4);
        cpu.access(15'h0, 8'h01, 1'b1, 4);
        m_cnt = 3'h2;
        probe(15'h0, 13'h0);
        reset_i <= 1'b1;
        @(posedge clock_i);
        reset_i <= 1'b0;
        {m_cfg, m_lo, m_hi, m_prg, m_cnt} = {5'h0c, 15'h0, 3'h0};
        probe(15'h4000, 13'h1234);
        $display("test serial sequence done");
        final_report();
    end
    initial begin
        repeat (40000) @(posedge clock_i);
        error_cnt++;
        final_report();
    end
endmodule // tb
`default_nettype wire
